// ### include/pdpc_pkg.sv
package pdpc_pkg;
  // management register indices
  localparam logic [4:0] PDPC_REG_CTRL = 5'h00;
  localparam logic [4:0] PDPC_REG_PLL = 5'h10;
  localparam logic [4:0] PDPC_REG_OSC = 5'h11;
  localparam logic [4:0] PDPC_REG_STRAP = 5'h16;
  localparam logic [4:0] PDPC_REG_ENERGY_DETECT_SLEEP = 5'h18;
  localparam logic [4:0] PDPC_REG_INT = 5'h1B;
  localparam logic [4:0] PDPC_REG_CABLE = 5'h1D;
  localparam logic [4:0] PDPC_REG_CTRL2 = 5'h1F;
  // control register 0 fields
  localparam int PDPC_C0_RESET = 15;
  localparam int PDPC_C0_LOOP = 14;
  localparam int PDPC_C0_SPEED = 13;
  localparam int PDPC_C0_ANEG = 12;
  localparam int PDPC_C0_PDOWN = 11;
  localparam int PDPC_C0_DUPLEX = 8;
  // other single-bit fields
  localparam int PDPC_PLL_OFF_BIT = 4;
  localparam int PDPC_SLOW_OSC_BIT = 5;
  localparam int PDPC_CHAIN_BIT = 5;
  localparam int PDPC_ENERGY_DETECT_SLEEP_OFF_BIT = 11;
  localparam int PDPC_LONG_PULSE_BIT = 0;
  localparam int PDPC_CBL_START_BIT = 15;
  localparam int PDPC_C2_MDIX_SEL = 14;
  localparam int PDPC_C2_MDIX_OFF = 13;
  localparam int PDPC_C2_PSAVE = 10;
  localparam int PDPC_C2_INT_HIGH = 9;
  localparam int PDPC_C2_RLOOP = 2;
  // interrupt status bits
  localparam int PDPC_INT_LINK_UP = 0;
  localparam int PDPC_INT_CABLE = 1;
  localparam int PDPC_INT_LINK_DOWN = 2;
  // values after reset
  localparam logic [15:0] PDPC_C0_RST_VAL = 16'h3100;
  localparam logic [15:0] PDPC_ENERGY_DETECT_SLEEP_RST_VAL = 16'h0800;
  localparam logic [15:0] PDPC_ZERO_RST_VAL = 16'h0000;
  // timing
  localparam int PDPC_CLK_MHZ = 25;
  localparam int PDPC_PULSE_US = 16000;
  localparam int PDPC_PULSE_CYCLES = PDPC_PULSE_US * PDPC_CLK_MHZ;
  localparam int PDPC_SETTLE_CYCLES = 4;
  localparam int PDPC_CHAIN_LEN = 19;
  // host register byte offsets
  localparam logic [7:0] PDPC_H_CMD = 8'h00;
  localparam logic [7:0] PDPC_H_MSTAT = 8'h04;
  localparam logic [7:0] PDPC_H_CHCTL = 8'h08;
  localparam logic [7:0] PDPC_H_CHSTAT = 8'h0C;
  // host command word fields
  localparam int PDPC_CMD_ADDR_LSB = 16;
  localparam int PDPC_CMD_WE = 24;
  localparam int PDPC_CMD_GO = 25;
endpackage : pdpc_pkg

// ### include/pdpc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pdpc_if #(parameter int CHAIN_N = 19);
  // management access
  logic mgmt_req;
  logic mgmt_we;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata;
  logic mgmt_ack;
  logic [15:0] mgmt_rdata;
  // mac transmit and receive nibbles
  logic [3:0] mac_txd;
  logic mac_tx_en;
  logic [3:0] mac_rxd;
  logic mac_rx_dv;
  // event line and board test pins
  logic interrupt_output;
  logic chain_strap_n;
  logic [CHAIN_N-1:0] chain_in;
  logic chain_result_pin;
  modport dev (input mgmt_req, mgmt_we, mgmt_addr, mgmt_wdata, mac_txd,
    mac_tx_en, chain_strap_n, chain_in, output mgmt_ack, mgmt_rdata,
    mac_rxd, mac_rx_dv, interrupt_output, chain_result_pin);
  modport hst (output mgmt_req, mgmt_we, mgmt_addr, mgmt_wdata, mac_txd,
    mac_tx_en, chain_strap_n, chain_in, input mgmt_ack, mgmt_rdata,
    mac_rxd, mac_rx_dv, interrupt_output, chain_result_pin);
endinterface : pdpc_if
`default_nettype wire

// ### hdl/pdpc_device.sv
`timescale 1ns/1ps
`default_nettype none
module pdpc_device #(
  parameter int CHAIN_N = pdpc_pkg::PDPC_CHAIN_LEN,
  parameter int PULSE_CYCLES = pdpc_pkg::PDPC_PULSE_CYCLES,
  parameter int CBL_W = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link to the host end
  pdpc_if.dev bus,
  // line side stream
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_dv,
  output logic [3:0] line_txd,
  output logic line_tx_en,
  output logic link_pulse,
  // line status
  input wire logic link_up,
  input wire logic aneg_100_full,
  input wire logic cable_echo,
  // crossover control for the cable test
  output logic mdix_auto_off,
  output logic mdix_cross,
  // power controls
  output logic rx_power_on,
  output logic pll_power_on,
  output logic tx_power_on,
  output logic energy_det_on,
  output logic slow_osc_sel,
  output logic core_enable
);
  import pdpc_pkg::*;

  logic [15:0] c0_reg; // control 0
  logic [15:0] pll_reg; // pll auto-off
  logic [15:0] osc_reg; // slow oscillator
  logic [15:0] strap_reg; // chain enable
  logic [15:0] energy_detect_sleep_reg; // sleep disable
  logic [15:0] c2_reg; // control 2
  logic [7:0] int_en_reg; // interrupt enables
  logic [7:0] int_st_reg; // interrupt status
  logic [7:0] int_set; // events this cycle
  logic soft_rst_reg; // one-cycle software reset
  logic cbl_busy_reg;
  logic [CBL_W-1:0] cbl_cnt_reg;
  logic [CBL_W-1:0] cbl_res_reg;
  logic cbl_done;
  logic link_prev_reg;
  logic [15:0] rdata_next;
  logic wr;
  logic rd;
  logic pd;
  logic no_aneg_link;
  logic psave;
  logic sleep;
  logic full100;
  logic local_lb;
  logic remote_lb;
  logic strap_s1_reg;
  logic strap_s2_reg;
  logic strap_seen_reg;
  logic strap_lat_reg;
  logic [31:0] pulse_cnt_reg;
  logic [31:0] pulse_lim;
  logic [CHAIN_N:0] stage;

  assign wr = bus.mgmt_req & bus.mgmt_we;
  assign rd = bus.mgmt_req & ~bus.mgmt_we;

  // register writes; software reset returns each register written here to defaults
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      c0_reg <= PDPC_C0_RST_VAL;
      pll_reg <= PDPC_ZERO_RST_VAL;
      osc_reg <= PDPC_ZERO_RST_VAL;
      strap_reg <= PDPC_ZERO_RST_VAL;
      energy_detect_sleep_reg <= PDPC_ENERGY_DETECT_SLEEP_RST_VAL;
      c2_reg <= PDPC_ZERO_RST_VAL;
      int_en_reg <= 8'h00;
    end
    else if (soft_rst_reg)
    begin
      c0_reg <= PDPC_C0_RST_VAL;
      pll_reg <= PDPC_ZERO_RST_VAL;
      osc_reg <= PDPC_ZERO_RST_VAL;
      strap_reg <= PDPC_ZERO_RST_VAL;
      energy_detect_sleep_reg <= PDPC_ENERGY_DETECT_SLEEP_RST_VAL;
      c2_reg <= PDPC_ZERO_RST_VAL;
      int_en_reg <= 8'h00;
    end
    else if (wr)
    begin
      case (bus.mgmt_addr)
        PDPC_REG_CTRL: c0_reg <= bus.mgmt_wdata & 16'h7FFF;
        PDPC_REG_PLL: pll_reg <= bus.mgmt_wdata;
        PDPC_REG_OSC: osc_reg <= bus.mgmt_wdata;
        PDPC_REG_STRAP: strap_reg <= bus.mgmt_wdata;
        PDPC_REG_ENERGY_DETECT_SLEEP: energy_detect_sleep_reg <= bus.mgmt_wdata;
        PDPC_REG_CTRL2: c2_reg <= bus.mgmt_wdata;
        PDPC_REG_INT: int_en_reg <= bus.mgmt_wdata[15:8];
        default: ; // other indices are not held here
      endcase
    end
  end

  // software reset pulse; self-clearing so it reads back zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      soft_rst_reg <= 1'b0;
    else
      soft_rst_reg <= wr && bus.mgmt_addr == PDPC_REG_CTRL
        && bus.mgmt_wdata[PDPC_C0_RESET];
  end

  // cable test: count cycles to the echo, the count is the distance
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cbl_busy_reg <= 1'b0;
      cbl_cnt_reg <= '0;
      cbl_res_reg <= '0;
    end
    else if (!cbl_busy_reg)
    begin
      // start only while idle; a start during a run is ignored
      if (wr && bus.mgmt_addr == PDPC_REG_CABLE
          && bus.mgmt_wdata[PDPC_CBL_START_BIT])
      begin
        cbl_busy_reg <= 1'b1;
        cbl_cnt_reg <= '0;
      end
    end
    else if (cbl_done)
    begin
      cbl_busy_reg <= 1'b0;
      cbl_res_reg <= cbl_cnt_reg;
    end
    else
      cbl_cnt_reg <= cbl_cnt_reg + 1'b1;
  end
  // an open cable never echoes, so the count saturates
  assign cbl_done = cbl_busy_reg & (cable_echo | (&cbl_cnt_reg));
  assign mdix_auto_off = c2_reg[PDPC_C2_MDIX_OFF];
  assign mdix_cross = c2_reg[PDPC_C2_MDIX_SEL];

  // interrupt events
  always_comb
  begin
    int_set = 8'h00;
    int_set[PDPC_INT_LINK_UP] = link_up & ~link_prev_reg;
    int_set[PDPC_INT_LINK_DOWN] = ~link_up & link_prev_reg;
    int_set[PDPC_INT_CABLE] = cbl_done;
  end

  // status clears on read, a new event in the same cycle survives
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_st_reg <= 8'h00;
      link_prev_reg <= 1'b0;
    end
    else
    begin
      link_prev_reg <= link_up;
      if (rd && bus.mgmt_addr == PDPC_REG_INT)
        int_st_reg <= int_set;
      else
        int_st_reg <= int_st_reg | int_set;
    end
  end
  assign bus.interrupt_output = (|(int_st_reg & int_en_reg))
    ~^ c2_reg[PDPC_C2_INT_HIGH];

  // read mux
  always_comb
  begin
    case (bus.mgmt_addr)
      PDPC_REG_CTRL: rdata_next = c0_reg;
      PDPC_REG_PLL: rdata_next = pll_reg;
      PDPC_REG_OSC: rdata_next = osc_reg;
      PDPC_REG_STRAP: rdata_next = strap_reg;
      PDPC_REG_ENERGY_DETECT_SLEEP: rdata_next = energy_detect_sleep_reg;
      PDPC_REG_CTRL2: rdata_next = c2_reg;
      PDPC_REG_INT: rdata_next = {int_en_reg, int_st_reg};
      PDPC_REG_CABLE: rdata_next = {cbl_busy_reg, 7'h00, 8'(cbl_res_reg)};
      default: rdata_next = 16'h0000;
    endcase
  end

  // management answers one cycle after the request, even in power down
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus.mgmt_ack <= 1'b0;
      bus.mgmt_rdata <= 16'h0000;
    end
    else
    begin
      bus.mgmt_ack <= bus.mgmt_req;
      if (bus.mgmt_req)
        bus.mgmt_rdata <= rdata_next;
    end
  end

  // power state
  assign pd = c0_reg[PDPC_C0_PDOWN];
  assign no_aneg_link = c0_reg[PDPC_C0_ANEG] & ~link_up;
  assign psave = c2_reg[PDPC_C2_PSAVE] & no_aneg_link;
  assign sleep = ~energy_detect_sleep_reg[PDPC_ENERGY_DETECT_SLEEP_OFF_BIT] & no_aneg_link;
  assign core_enable = ~pd;
  assign rx_power_on = ~pd & ~psave & ~sleep;
  assign pll_power_on = ~pd & ~(sleep & pll_reg[PDPC_PLL_OFF_BIT]);
  assign tx_power_on = ~pd;
  assign energy_det_on = ~pd;
  assign slow_osc_sel = osc_reg[PDPC_SLOW_OSC_BIT];

  // link pulses while asleep; the long-interval bit doubles the gap
  assign pulse_lim = energy_detect_sleep_reg[PDPC_LONG_PULSE_BIT]
    ? 32'(2 * PULSE_CYCLES - 1) : 32'(PULSE_CYCLES - 1);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pulse_cnt_reg <= 32'h0000_0000;
      link_pulse <= 1'b0;
    end
    else if (!sleep || pd)
    begin
      pulse_cnt_reg <= 32'h0000_0000;
      link_pulse <= 1'b0;
    end
    else
    begin
      link_pulse <= pulse_cnt_reg == pulse_lim;
      pulse_cnt_reg <= (pulse_cnt_reg == pulse_lim)
        ? 32'h0000_0000 : pulse_cnt_reg + 32'h0000_0001;
    end
  end

  // loopback selection
  assign full100 = c0_reg[PDPC_C0_ANEG] ? aneg_100_full
    : (c0_reg[PDPC_C0_SPEED] & c0_reg[PDPC_C0_DUPLEX]);
  assign local_lb = c0_reg[PDPC_C0_LOOP] & ~pd;
  assign remote_lb = c2_reg[PDPC_C2_RLOOP] & full100 & link_up & ~pd;

  // data paths; a held-off path sends idle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus.mac_rxd <= 4'h0;
      bus.mac_rx_dv <= 1'b0;
      line_txd <= 4'h0;
      line_tx_en <= 1'b0;
    end
    else
    begin
      if (local_lb)
      begin
        bus.mac_rxd <= bus.mac_txd;
        bus.mac_rx_dv <= bus.mac_tx_en;
      end
      else
      begin
        bus.mac_rxd <= line_rxd & {4{rx_power_on & ~remote_lb}};
        bus.mac_rx_dv <= line_rx_dv & rx_power_on & ~remote_lb;
      end
      if (remote_lb)
      begin
        line_txd <= line_rxd;
        line_tx_en <= line_rx_dv;
      end
      else
      begin
        line_txd <= bus.mac_txd & {4{~local_lb & ~pd}};
        line_tx_en <= bus.mac_tx_en & ~local_lb & ~pd;
      end
    end
  end

  // strap pin: synchronised, but caught on the first edge after reset release, before the synchroniser passes the pin, so it latches low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strap_s1_reg <= 1'b1;
      strap_s2_reg <= 1'b1;
      strap_seen_reg <= 1'b0;
      strap_lat_reg <= 1'b0;
    end
    else
    begin
      strap_s1_reg <= bus.chain_strap_n;
      strap_s2_reg <= strap_s1_reg;
      strap_seen_reg <= 1'b1;
      if (!strap_seen_reg)
        strap_lat_reg <= ~strap_s2_reg;
    end
  end

  // nand chain, seed high so each pin low flips the whole tail
  assign stage[0] = 1'b1;
  genvar gi;
  generate
    for (gi = 0; gi < CHAIN_N; gi++)
    begin : g_chain
      assign stage[gi+1] = ~(bus.chain_in[gi] & stage[gi]);
    end
  endgenerate
  // odd lengths get a final inversion so all-high reads high
  assign bus.chain_result_pin = (strap_lat_reg | strap_reg[PDPC_CHAIN_BIT])
    & (stage[CHAIN_N] ^ 1'(CHAIN_N % 2));
endmodule : pdpc_device
`default_nettype wire

// ### hdl/pdpc_host.sv
`timescale 1ns/1ps
`default_nettype none
module pdpc_host #(
  parameter int CHAIN_N = pdpc_pkg::PDPC_CHAIN_LEN
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // mac stream
  input wire logic [3:0] tx_nibble,
  input wire logic tx_valid,
  output logic [3:0] rx_nibble,
  output logic rx_valid,
  // link to the device end
  pdpc_if.hst bus
);
  import pdpc_pkg::*;

  typedef enum {CH_IDLE, CH_HIGH, CH_STEP, CH_CHECK} pdpc_ch_type;
  pdpc_ch_type ch_state_reg;
  logic wr_pend_reg; // write data phase pending
  logic [7:0] wr_addr_reg;
  logic mbusy_reg;
  logic [15:0] mrdata_reg;
  logic strap_on_reg;
  logic [CHAIN_N-1:0] drive_reg;
  logic [CHAIN_N-1:0] fault_reg;
  logic [$clog2(CHAIN_N+1)-1:0] idx_reg;
  logic [3:0] wait_reg;
  logic res_s1_reg;
  logic res_s2_reg;
  logic prev_reg;
  logic chain_go;
  logic acc;

  assign acc = hsel & hready & htrans[1];
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0;
  assign chain_go = wr_pend_reg && wr_addr_reg == PDPC_H_CHCTL && hwdata[0];

  // address phase capture and registered read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= acc & hwrite;
      wr_addr_reg <= haddr[7:0];
      if (acc && !hwrite)
      begin
        case (haddr[7:0])
          PDPC_H_MSTAT: hrdata <= {14'h0000, bus.interrupt_output,
            mbusy_reg, mrdata_reg};
          PDPC_H_CHCTL: hrdata <= {31'h0000_0000, strap_on_reg};
          PDPC_H_CHSTAT: hrdata <= 32'({fault_reg, 11'h000,
            ch_state_reg != CH_IDLE});
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // management master: one request per command, wait for the answer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus.mgmt_req <= 1'b0;
      bus.mgmt_we <= 1'b0;
      bus.mgmt_addr <= 5'h00;
      bus.mgmt_wdata <= 16'h0000;
      mbusy_reg <= 1'b0;
      mrdata_reg <= 16'h0000;
    end
    else
    begin
      bus.mgmt_req <= 1'b0;
      if (wr_pend_reg && wr_addr_reg == PDPC_H_CMD && hwdata[PDPC_CMD_GO]
          && !mbusy_reg)
      begin
        bus.mgmt_req <= 1'b1;
        bus.mgmt_we <= hwdata[PDPC_CMD_WE];
        bus.mgmt_addr <= hwdata[PDPC_CMD_ADDR_LSB +: 5];
        bus.mgmt_wdata <= hwdata[15:0];
        mbusy_reg <= 1'b1;
      end
      else if (bus.mgmt_ack)
      begin
        mbusy_reg <= 1'b0;
        mrdata_reg <= bus.mgmt_rdata;
      end
    end
  end

  // chain result is a pin level: two flops before use
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      res_s1_reg <= 1'b0;
      res_s2_reg <= 1'b0;
    end
    else
    begin
      res_s1_reg <= bus.chain_result_pin;
      res_s2_reg <= res_s1_reg;
    end
  end

  // strap control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      strap_on_reg <= 1'b0;
    else if (wr_pend_reg && wr_addr_reg == PDPC_H_CHCTL)
      strap_on_reg <= hwdata[1];
  end
  assign bus.chain_strap_n = ~strap_on_reg;

  // chain walk: all high, then each pin low in order, check toggles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ch_state_reg <= CH_IDLE;
      drive_reg <= '1;
      fault_reg <= '0;
      idx_reg <= '0;
      wait_reg <= 4'h0;
      prev_reg <= 1'b0;
    end
    else
    begin
      case (ch_state_reg)
        CH_IDLE:
        begin
          if (chain_go)
          begin
            drive_reg <= '1;
            fault_reg <= '0;
            idx_reg <= '0;
            wait_reg <= 4'(PDPC_SETTLE_CYCLES);
            ch_state_reg <= CH_HIGH;
          end
        end
        CH_HIGH:
        begin
          if (wait_reg == 4'h0)
          begin
            prev_reg <= res_s2_reg;
            ch_state_reg <= CH_STEP;
          end
          else
            wait_reg <= wait_reg - 4'h1;
        end
        CH_STEP:
        begin
          drive_reg[idx_reg] <= 1'b0;
          wait_reg <= 4'(PDPC_SETTLE_CYCLES);
          ch_state_reg <= CH_CHECK;
        end
        CH_CHECK:
        begin
          if (wait_reg != 4'h0)
            wait_reg <= wait_reg - 4'h1;
          else
          begin
            fault_reg[idx_reg] <= res_s2_reg == prev_reg;
            prev_reg <= res_s2_reg;
            idx_reg <= idx_reg + 1'b1;
            ch_state_reg <= (idx_reg == CHAIN_N - 1) ? CH_IDLE : CH_STEP;
          end
        end
        default: ch_state_reg <= CH_IDLE;
      endcase
    end
  end
  assign bus.chain_in = drive_reg;

  // mac stream passes straight through
  assign bus.mac_txd = tx_nibble;
  assign bus.mac_tx_en = tx_valid;
  assign rx_nibble = bus.mac_rxd;
  assign rx_valid = bus.mac_rx_dv;
endmodule : pdpc_host
`default_nettype wire

// ### testbench/pdpc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pdpc_checker
  import pdpc_pkg::*;
#(
  parameter int CHAIN_N = 19
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // management access
  input wire logic mgmt_req,
  input wire logic mgmt_we,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_ack,
  input wire logic [15:0] mgmt_rdata,
  // mac streams
  input wire logic [3:0] mac_txd,
  input wire logic mac_tx_en,
  input wire logic [3:0] mac_rxd,
  input wire logic mac_rx_dv,
  // chain pins
  input wire logic [CHAIN_N-1:0] chain_in,
  input wire logic chain_result_pin
);
  // mode shadows rebuilt from management writes
  logic loop_on;
  logic pdown_on;
  logic chain_on;
  logic wr_ctrl;
  logic lp;
  assign wr_ctrl = mgmt_req && mgmt_we && mgmt_addr == PDPC_REG_CTRL;
  assign lp = loop_on && !pdown_on;
  // a soft reset write clears the shadows early, which only mutes checks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      loop_on <= 1'b0;
      pdown_on <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      loop_on <= mgmt_wdata[PDPC_C0_LOOP] && !mgmt_wdata[PDPC_C0_RESET];
      pdown_on <= mgmt_wdata[PDPC_C0_PDOWN] && !mgmt_wdata[PDPC_C0_RESET];
    end
  end
  // chain mode shadow, register path only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      chain_on <= 1'b0;
    else if (wr_ctrl && mgmt_wdata[PDPC_C0_RESET])
      chain_on <= 1'b0;
    else if (mgmt_req && mgmt_we && mgmt_addr == PDPC_REG_STRAP)
      chain_on <= mgmt_wdata[PDPC_CHAIN_BIT];
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_MGMT_ALIVE: assert property (mgmt_req |=> mgmt_ack)
    else $error("no acknowledge after request");
  AST_ACK_CAUSE: assert property (mgmt_ack |-> $past(mgmt_req))
    else $error("acknowledge without request");
  AST_REQ_SPACING: assert property (mgmt_req |=> !mgmt_req [*2])
    else $error("requests too close");
  AST_RDATA_HOLD: assert property (!mgmt_ack && !$past(mgmt_req)
    && !$past(mgmt_req, 2) |-> $stable(mgmt_rdata))
    else $error("read data moved without request");
  AST_LOCAL_LOOP: assert property (lp && $past(lp) && $past(lp, 2)
    |-> mac_rx_dv == $past(mac_tx_en)
    && (!mac_rx_dv || mac_rxd == $past(mac_txd)))
    else $error("local loop data mismatch");
  AST_PDOWN_IDLE: assert property (pdown_on && $past(pdown_on, 2)
    |-> !mac_rx_dv)
    else $error("receive active in power down");
  AST_CHAIN_TOGGLE: assert property (chain_on && $past(chain_on)
    && $past(chain_in) != '0
    && ($past(chain_in) | ($past(chain_in) - 1'b1)) == '1
    && chain_in == ($past(chain_in) & ($past(chain_in) - 1'b1))
    |-> chain_result_pin != $past(chain_result_pin))
    else $error("chain output did not toggle");
  AST_CHAIN_OFF: assert property (!chain_on && !$past(chain_on, 2)
    |-> !chain_result_pin)
    else $error("chain output high outside chain mode");
endmodule : pdpc_checker
`default_nettype wire

// ### testbench/test_phy_diag_power_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_phy_diag_power_control;
  import pdpc_pkg::*;
  // clock, reset and bus master
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  // mac and line stimulus; the echo stays tied
  logic [3:0] tx_nibble = 4'h0;
  logic tx_valid = 1'b0;
  logic [3:0] line_rxd = 4'h0;
  logic line_rx_dv = 1'b0;
  logic link_up = 1'b0;
  logic aneg_100_full = 1'b0;
  logic cable_echo = 1'b0;
  wire logic [3:0] rx_nibble;
  wire logic [3:0] line_txd;
  wire logic rx_valid, line_tx_en, link_pulse, mdix_auto_off, mdix_cross;
  wire logic rx_power_on, pll_power_on, tx_power_on, energy_det_on;
  wire logic slow_osc_sel, core_enable;
  // bookkeeping
  int errors = 0;
  int check_count = 0;
  logic [31:0] pulses;
  logic [15:0] r16;
  int n;
  always #20 hclk = ~hclk;
  pdpc_if #(.CHAIN_N(19)) link ();
  pdpc_host #(.CHAIN_N(19)) i_pdpc_host (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hrdata, .hresp, .tx_nibble, .tx_valid, .rx_nibble, .rx_valid,
    .bus(link.hst));
  pdpc_device #(.CHAIN_N(19), .PULSE_CYCLES(20), .CBL_W(8)) i_pdpc_device (
    .hclk, .hresetn, .bus(link.dev), .line_rxd, .line_rx_dv, .line_txd,
    .line_tx_en, .link_pulse, .link_up, .aneg_100_full, .cable_echo,
    .mdix_auto_off, .mdix_cross, .rx_power_on, .pll_power_on, .tx_power_on,
    .energy_det_on, .slow_osc_sel, .core_enable);
  pdpc_checker #(.CHAIN_N(19)) i_pdpc_checker (.hclk, .hresetn,
    .mgmt_req(link.mgmt_req), .mgmt_we(link.mgmt_we),
    .mgmt_addr(link.mgmt_addr), .mgmt_wdata(link.mgmt_wdata),
    .mgmt_ack(link.mgmt_ack), .mgmt_rdata(link.mgmt_rdata),
    .mac_txd(link.mac_txd), .mac_tx_en(link.mac_tx_en),
    .mac_rxd(link.mac_rxd), .mac_rx_dv(link.mac_rx_dv),
    .chain_in(link.chain_in), .chain_result_pin(link.chain_result_pin));
  // verdict and end of run
  task automatic complete_run;
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : chk1
  // a used-up bound counts as a mismatch and ends the run
  task automatic timeout_if(input logic bad);
    if (bad)
    begin
      errors++;
      complete_run();
    end
  endtask : timeout_if
  // waits for hready sampled high, bounded
  task automatic wait_ready;
    int k;
    @(posedge hclk);
    for (k = 0; hreadyout !== 1'b1; k++)
    begin
      timeout_if(k == 50);
      @(posedge hclk);
    end
  endtask : wait_ready
  // one single word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] r);
    haddr <= {24'h0, a};
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask : ahb
  // polls a status word until the given bit is low
  task automatic waitbit(input logic [7:0] a, input int b,
    output logic [31:0] s);
    int k;
    for (k = 0; k < 200; k++)
    begin
      ahb(1'b0, a, 32'h0, s);
      if (s[b] === 1'b0)
        break;
    end
    timeout_if(k == 200);
  endtask : waitbit
  // one management access through the command word
  task automatic mreg(input logic w, input logic [4:0] idx,
    input logic [15:0] v, output logic [15:0] r);
    logic [31:0] s;
    ahb(1'b1, PDPC_H_CMD, {6'h0, 1'b1, w, 3'h0, idx, v}, s);
    waitbit(PDPC_H_MSTAT, 16, s);
    r = s[15:0];
  endtask : mreg
  task automatic wr(input logic [4:0] idx, input logic [15:0] v);
    mreg(1'b1, idx, v, r16);
  endtask : wr
  task automatic rdchk(input logic [4:0] idx, input logic [15:0] e);
    mreg(1'b0, idx, 16'h0, r16);
    check({16'h0, r16}, {16'h0, e});
  endtask : rdchk
  // eight nibbles through a loop; the released lines show inverted data
  task automatic stream(input logic remote);
    int i;
    logic [5:0] seen;
    for (i = 0; i < 8; i++)
    begin
      tx_nibble <= i[3:0];
      line_rxd <= i[3:0];
      tx_valid <= !remote;
      line_rx_dv <= remote;
      @(posedge hclk);
      @(negedge hclk);
      seen = remote ? {line_tx_en, line_txd, rx_valid}
        : {rx_valid, rx_nibble, line_tx_en};
      check({26'h0, seen}, {26'h0, 1'b1, i[3:0], 1'b0});
      @(posedge hclk);
    end
    tx_valid <= 1'b0;
    line_rx_dv <= 1'b0;
    tx_nibble <= ~tx_nibble;
    line_rxd <= ~line_rxd;
    @(posedge hclk);
  endtask : stream
  task automatic chain_walk(input logic [31:0] e);
    logic [31:0] s;
    ahb(1'b1, PDPC_H_CHCTL, 32'h0000_0001, s);
    waitbit(PDPC_H_CHSTAT, 0, s);
    check(s, e);
  endtask : chain_walk
  // main sequence
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(PDPC_REG_CTRL, 16'h3100);
    rdchk(PDPC_REG_ENERGY_DETECT_SLEEP, 16'h0800);
    rdchk(PDPC_REG_CTRL2, 16'h0000);
    check({30'h0, rx_power_on, core_enable}, 32'h3);
    // power saving, no link then link
    wr(PDPC_REG_CTRL2, 16'h0400);
    check({28'h0, rx_power_on, pll_power_on, tx_power_on,
      energy_det_on}, 32'h7);
    link_up <= 1'b1;
    repeat (2) @(posedge hclk);
    chk1(rx_power_on, 1'b1);
    link_up <= 1'b0;
    wr(PDPC_REG_CTRL2, 16'h0000);
    // sleep with link pulses, then pll off
    wr(PDPC_REG_ENERGY_DETECT_SLEEP, 16'h0000);
    chk1(rx_power_on, 1'b0);
    pulses = 0;
    repeat (100)
    begin
      @(posedge hclk);
      if (link_pulse === 1'b1)
        pulses++;
    end
    check(pulses, 32'h0000_0005);
    wr(PDPC_REG_PLL, 16'h0010);
    check({29'h0, pll_power_on, tx_power_on, energy_det_on},
      32'h3);
    // power down with traffic, slow oscillator, exit sequence
    tx_valid <= 1'b1;
    wr(PDPC_REG_CTRL, 16'h7900);
    rdchk(PDPC_REG_CTRL, 16'h7900);
    chk1(core_enable, 1'b0);
    wr(PDPC_REG_OSC, 16'h0020);
    chk1(slow_osc_sel, 1'b1);
    tx_valid <= 1'b0;
    wr(PDPC_REG_OSC, 16'h0000);
    wr(PDPC_REG_CTRL, 16'h3100);
    wr(PDPC_REG_CTRL, 16'h8000);
    rdchk(PDPC_REG_ENERGY_DETECT_SLEEP, 16'h0800);
    check({30'h0, slow_osc_sel, core_enable}, 32'h1);
    // local loop at 100 and at 10
    for (n = 0; n < 2; n++)
    begin
      wr(PDPC_REG_CTRL, n == 0 ? 16'h6100 : 16'h4100);
      stream(1'b0);
    end
    // remote loop forced and negotiated at 100 full, refused at 10
    wr(PDPC_REG_CTRL, 16'h8000);
    link_up <= 1'b1;
    aneg_100_full <= 1'b1;
    for (n = 0; n < 2; n++)
    begin
      wr(PDPC_REG_CTRL, n == 0 ? 16'h2100 : 16'h3100);
      wr(PDPC_REG_CTRL2, 16'h0004);
      stream(1'b1);
    end
    wr(PDPC_REG_CTRL, 16'h0100);
    line_rx_dv <= 1'b1;
    repeat (2) @(posedge hclk);
    chk1(line_tx_en, 1'b0);
    line_rx_dv <= 1'b0;
    // cable test on a forced pair, result and interrupt
    wr(PDPC_REG_CTRL, 16'h8000);
    wr(PDPC_REG_INT, 16'h0200);
    mreg(1'b0, PDPC_REG_INT, 16'h0, r16);
    wr(PDPC_REG_CTRL2, 16'h6000);
    check({30'h0, mdix_auto_off, mdix_cross}, 32'h3);
    wr(PDPC_REG_CABLE, 16'h8000);
    for (n = 0; n < 60; n++)
    begin
      mreg(1'b0, PDPC_REG_CABLE, 16'h0, r16);
      if (r16[15] === 1'b0)
        break;
    end
    timeout_if(n == 60);
    check({16'h0, r16}, 32'h0000_00FF);
    chk1(link.interrupt_output, 1'b0);
    rdchk(PDPC_REG_INT, 16'h0202);
    chk1(link.interrupt_output, 1'b1);
    rdchk(PDPC_REG_INT, 16'h0200);
    // chain walk outside chain mode, then inside it
    chain_walk(32'h7FFF_F000);
    wr(PDPC_REG_STRAP, 16'h0020);
    chain_walk(32'h0000_0000);
    complete_run();
  end
endmodule : test_phy_diag_power_control
`default_nettype wire
